// ==== pdc_pkg.sv ====
// Constants, field layouts and carrier types for the device capability/control registers
package pdc_pkg;

    // Byte addresses on the register bus
    localparam logic [7:0] PDC_DEV_CAP_OFF   = 8'hB4;
    localparam logic [7:0] PDC_DEV_CTRL_OFF  = 8'hB8;

    // Cycles after reset release before the synced straps are caught
    localparam logic [1:0] PDC_STRAP_SETTLE  = 2'h2;

    // Device capability fields
    localparam int         PDC_CAP_MPS_LSB   = 0;
    localparam logic [2:0] PDC_CAP_MPS_RST   = 3'h1;
    localparam int         PDC_CAP_TAG8_BIT  = 5;
    localparam logic [0:0] PDC_CAP_TAG8_RST  = 1'h1;
    localparam int         PDC_CAP_L1_LSB    = 9;
    localparam logic [2:0] PDC_CAP_L1_RST    = 3'h0;
    localparam int         PDC_CAP_ABP_BIT   = 12;
    localparam int         PDC_CAP_AIP_BIT   = 13;
    localparam int         PDC_CAP_PIP_BIT   = 14;
    localparam int         PDC_CAP_SPV_LSB   = 18;
    localparam logic [7:0] PDC_CAP_SPV_RST   = 8'h00;
    localparam int         PDC_CAP_SPS_LSB   = 26;
    localparam logic [1:0] PDC_CAP_SPS_RST   = 2'h0;

    // Device control fields
    localparam int         PDC_CTL_ERR_LSB   = 0;
    localparam logic [3:0] PDC_CTL_ERR_RST   = 4'h0;
    localparam int         PDC_CTL_MPS_LSB   = 5;
    localparam logic [2:0] PDC_CTL_MPS_RST   = 3'h0;
    localparam int         PDC_CTL_ETAG_BIT  = 8;
    localparam logic [0:0] PDC_CTL_ETAG_RST  = 1'h0;
    localparam int         PDC_CTL_MRRS_LSB  = 12;
    localparam logic [2:0] PDC_CTL_MRRS_RST  = 3'h2;
    localparam int         PDC_CTL_RETRY_BIT = 15;
    localparam logic [0:0] PDC_CTL_RETRY_RST = 1'h0;

    // Set_Slot_Power_Limit payload as delivered by the message decoder
    typedef struct packed {
        logic       valid;
        logic [1:0] scale;
        logic [7:0] value;
    } pdc_ssp_msg_s;

    // Control settings driven into the bridge core
    typedef struct packed {
        logic [3:0] err_report_en;
        logic [2:0] max_payload;
        logic       ext_tag_en;
        logic [2:0] max_read_req;
        logic       cfg_retry_en;
        logic       no_snoop_en;
        logic       relaxed_ord_en;
    } pdc_dev_ctrl_s;

endpackage : pdc_pkg

// ==== pdc_regs.sv ====
// Device capability and device control registers behind an Avalon-MM slave
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps

module pdc_regs #(
    parameter logic [2:0] L1_LATENCY = pdc_pkg::PDC_CAP_L1_RST
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,

    // Straps from pins
    input  wire logic                   hot_plug_strap_i,
    input  wire logic                   forward_bridge_strap_i,

    // Slot power limit message from the receive path
    input  wire pdc_pkg::pdc_ssp_msg_s  ssp_msg_i,

    // Avalon-MM slave
    input  wire logic [7:0]             avs_address_i,
    input  wire logic                   avs_read_i,
    input  wire logic                   avs_write_i,
    input  wire logic [31:0]            avs_writedata_i,
    input  wire logic [3:0]             avs_byteenable_i,
    output logic [31:0]                 avs_readdata_o,
    output logic                        avs_waitrequest_o,

    // Control settings to the core
    output pdc_pkg::pdc_dev_ctrl_s      dev_ctrl_o,
    output logic                        hot_plug_en_o
);

    // Strap synchronisers
    logic       hp_meta;
    logic       hp_sync;
    logic       fwd_meta;
    logic       fwd_sync;

    // Straps as caught after reset release
    logic       strap_taken;
    logic       hot_plug_en;
    logic       forward_bridge;

    // Capability state
    logic       ind_present;
    logic [7:0] slot_pwr_value;
    logic [1:0] slot_pwr_scale;

    // Control state
    logic [3:0] err_report_en;
    logic [2:0] max_payload;
    logic       ext_tag_en;
    logic [2:0] max_read_req;
    logic       cfg_retry_en;

    // Bus handshake
    logic        bus_req;
    logic        bus_ack;
    logic        wr_fire;
    logic        sel_cap;
    logic        sel_ctrl;
    logic [31:0] cap_word;
    logic [31:0] ctrl_word;
    logic [31:0] next_readdata;

    // Two flops before any logic sees the straps
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hp_meta  <= 1'b0;
            hp_sync  <= 1'b0;
            fwd_meta <= 1'b0;
            fwd_sync <= 1'b0;
        end else begin
            hp_meta  <= hot_plug_strap_i;
            hp_sync  <= hp_meta;
            fwd_meta <= forward_bridge_strap_i;
            fwd_sync <= fwd_meta;
        end
    end

    // Straps are caught once, on the third edge after release, so the sync chain has settled
    logic [1:0] settle;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            strap_taken    <= 1'b0;
            hot_plug_en    <= 1'b0;
            forward_bridge <= 1'b0;
        end else if (!strap_taken && settle == pdc_pkg::PDC_STRAP_SETTLE) begin
            strap_taken    <= 1'b1;
            hot_plug_en    <= hp_sync;
            forward_bridge <= fwd_sync;
        end
    end

    // Indicator presence takes the strap value as its reset value
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ind_present <= 1'b0;
        end else if (!strap_taken && settle == pdc_pkg::PDC_STRAP_SETTLE) begin
            ind_present <= hp_sync;
        end
    end

    assign hot_plug_en_o = hot_plug_en;

    // Value and scale move as one so software never sees a torn pair
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            slot_pwr_value <= pdc_pkg::PDC_CAP_SPV_RST;
            slot_pwr_scale <= pdc_pkg::PDC_CAP_SPS_RST;
        end else if (ssp_msg_i.valid) begin
            slot_pwr_value <= ssp_msg_i.value;
            slot_pwr_scale <= ssp_msg_i.scale;
        end
    end

    // Capability word as read
    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[pdc_pkg::PDC_CAP_MPS_LSB +: 3] = pdc_pkg::PDC_CAP_MPS_RST;
        cap_word[pdc_pkg::PDC_CAP_TAG8_BIT] = pdc_pkg::PDC_CAP_TAG8_RST[0];
        cap_word[pdc_pkg::PDC_CAP_L1_LSB +: 3] = L1_LATENCY;
        cap_word[pdc_pkg::PDC_CAP_ABP_BIT] = hot_plug_en & forward_bridge;
        cap_word[pdc_pkg::PDC_CAP_AIP_BIT] = ind_present;
        cap_word[pdc_pkg::PDC_CAP_PIP_BIT] = ind_present;
        cap_word[pdc_pkg::PDC_CAP_SPV_LSB +: 8] = slot_pwr_value;
        cap_word[pdc_pkg::PDC_CAP_SPS_LSB +: 2] = slot_pwr_scale;
    end

    // Control word as read; unsupported enables and status half read zero
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[pdc_pkg::PDC_CTL_ERR_LSB +: 4] = err_report_en;
        ctrl_word[pdc_pkg::PDC_CTL_MPS_LSB +: 3] = max_payload;
        ctrl_word[pdc_pkg::PDC_CTL_ETAG_BIT] = ext_tag_en;
        ctrl_word[pdc_pkg::PDC_CTL_MRRS_LSB +: 3] = max_read_req;
        ctrl_word[pdc_pkg::PDC_CTL_RETRY_BIT] = cfg_retry_en;
    end

    // Decode
    assign sel_cap  = (avs_address_i == pdc_pkg::PDC_DEV_CAP_OFF);
    assign sel_ctrl = (avs_address_i == pdc_pkg::PDC_DEV_CTRL_OFF);
    assign bus_req  = avs_read_i | avs_write_i;

    // One wait cycle: data is registered before waitrequest drops
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    assign avs_waitrequest_o = bus_req & ~bus_ack;
    assign wr_fire           = avs_write_i & bus_ack;

    always_comb begin
        if (sel_cap) begin
            next_readdata = cap_word;
        end else if (sel_ctrl) begin
            next_readdata = ctrl_word;
        end else begin
            next_readdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !bus_ack) begin
            avs_readdata_o <= next_readdata;
        end
    end

    // Byte lane 0: error enables, payload size
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            err_report_en <= pdc_pkg::PDC_CTL_ERR_RST;
            max_payload   <= pdc_pkg::PDC_CTL_MPS_RST;
        end else if (wr_fire && sel_ctrl && avs_byteenable_i[0]) begin
            err_report_en <= avs_writedata_i[pdc_pkg::PDC_CTL_ERR_LSB +: 4];
            max_payload   <= avs_writedata_i[pdc_pkg::PDC_CTL_MPS_LSB +: 3];
        end
    end

    // Byte lane 1: extended tag, read request size, retry
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ext_tag_en   <= pdc_pkg::PDC_CTL_ETAG_RST[0];
            max_read_req <= pdc_pkg::PDC_CTL_MRRS_RST;
            cfg_retry_en <= pdc_pkg::PDC_CTL_RETRY_RST[0];
        end else if (wr_fire && sel_ctrl && avs_byteenable_i[1]) begin
            ext_tag_en   <= avs_writedata_i[pdc_pkg::PDC_CTL_ETAG_BIT];
            max_read_req <= avs_writedata_i[pdc_pkg::PDC_CTL_MRRS_LSB +: 3];
            cfg_retry_en <= avs_writedata_i[pdc_pkg::PDC_CTL_RETRY_BIT];
        end
    end

    // Reserved size codes are stored as written; the core must treat them itself
    always_comb begin
        dev_ctrl_o.err_report_en  = err_report_en;
        dev_ctrl_o.max_payload    = max_payload;
        dev_ctrl_o.ext_tag_en     = ext_tag_en;
        dev_ctrl_o.max_read_req   = max_read_req;
        dev_ctrl_o.cfg_retry_en   = cfg_retry_en;
        dev_ctrl_o.no_snoop_en    = 1'b0;
        dev_ctrl_o.relaxed_ord_en = 1'b0;
    end

endmodule : pdc_regs

// ==== pdc_regs_chk.sv ====
// Assertions on the capability/control register ports
`timescale 1ns/1ps
module pdc_regs_chk #(
    parameter logic [2:0] L1_LATENCY = 3'h0
) (
    input wire logic                   clk_i,
    input wire logic                   sys_rst_i,
    input wire logic                   hot_plug_strap_i,
    input wire logic                   forward_bridge_strap_i,
    input wire pdc_pkg::pdc_ssp_msg_s  ssp_msg_i,
    input wire logic [7:0]             avs_address_i,
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic [31:0]            avs_writedata_i,
    input wire logic [3:0]             avs_byteenable_i,
    input wire logic [31:0]            avs_readdata_o,
    input wire logic                   avs_waitrequest_o,
    input wire pdc_pkg::pdc_dev_ctrl_s dev_ctrl_o,
    input wire logic                   hot_plug_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic wr_ctl;
    assign wr_ctl = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'hB8;
    sequence s_rd(a);
        avs_read_i && !avs_waitrequest_o && avs_address_i == a;
    endsequence
    sequence s_wr(lane);
        wr_ctl && avs_byteenable_i[lane];
    endsequence
    chk_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("waitrequest held too long");
    chk_idle_ready: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest while idle");
    chk_ctrl_reset: assert property ($past(sys_rst_i) |-> dev_ctrl_o.max_read_req == 3'h2
        && dev_ctrl_o.err_report_en == 4'h0 && dev_ctrl_o.max_payload == 3'h0)
        else $error("control reset value");
    chk_fixed_zero: assert property (!dev_ctrl_o.no_snoop_en && !dev_ctrl_o.relaxed_ord_en)
        else $error("unsupported enable set");
    chk_ctrl_hold: assert property (!$stable(dev_ctrl_o) |-> $past(wr_ctl))
        else $error("control changed without write");
    chk_low_lane: assert property (s_wr(0) |=> dev_ctrl_o.err_report_en == $past(avs_writedata_i[3:0])
        && dev_ctrl_o.max_payload == $past(avs_writedata_i[7:5])) else $error("low lane write");
    chk_high_lane: assert property (s_wr(1) |=> dev_ctrl_o.max_read_req == $past(avs_writedata_i[14:12])
        && dev_ctrl_o.ext_tag_en == $past(avs_writedata_i[8])
        && dev_ctrl_o.cfg_retry_en == $past(avs_writedata_i[15])) else $error("high lane write");
    chk_cap_read: assert property (s_rd(8'hB4) |-> avs_readdata_o[11:9] == L1_LATENCY
        && avs_readdata_o[5] && avs_readdata_o[14:13] == {2{hot_plug_en_o}}
        && avs_readdata_o[17:15] == 3'h0 && avs_readdata_o[31:28] == 4'h0)
        else $error("capability read fields");
    chk_ctl_read: assert property (s_rd(8'hB8) |-> avs_readdata_o == {16'h0000,
        dev_ctrl_o.cfg_retry_en, dev_ctrl_o.max_read_req, 3'h0, dev_ctrl_o.ext_tag_en,
        dev_ctrl_o.max_payload, 1'b0, dev_ctrl_o.err_report_en}) else $error("control read");
endmodule : pdc_regs_chk

bind pdc_regs pdc_regs_chk #(.L1_LATENCY(L1_LATENCY)) u_pdc_regs_chk (.*);

// ==== pdc_link_partner.sv ====
// Link partner model sending slot power limit messages
`timescale 1ns/1ps
module pdc_link_partner (
    // Clock
    input  wire logic             clk_i,
    // Message to the receive path
    output pdc_pkg::pdc_ssp_msg_s msg_o
);
    initial msg_o = '0;
    task automatic send(input logic [7:0] value, input logic [1:0] scale);
        @(posedge clk_i);
        msg_o <= '{valid: 1'b1, scale: scale, value: value};
        @(posedge clk_i);
        // Stale payload inverted so nothing relies on it after the pulse
        msg_o <= '{valid: 1'b0, scale: ~scale, value: ~value};
    endtask : send
endmodule : pdc_link_partner

// ==== testbench.sv ====
// Self-checking bench for the capability/control registers
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  be;
        logic [31:0] exp;
    } pdc_row_s;
    localparam pdc_row_s ROWS [6] = '{
        '{32'hFFFFFFFF, 4'hF, 32'h0000F1EF}, '{32'h00000000, 4'h1, 32'h0000F100},
        '{32'h00000000, 4'h2, 32'h00000000}, '{32'h000000A5, 4'h1, 32'h000000A5},
        '{32'h00005A5A, 4'h3, 32'h0000504A}, '{32'h000000E0, 4'h1, 32'h000050E0}};
    logic                   clk_i = 1'b0;
    logic                   sys_rst_i = 1'b1;
    logic                   hp_strap = 1'b1;
    logic                   fwd_strap = 1'b1;
    pdc_pkg::pdc_ssp_msg_s  ssp_msg;
    logic [7:0]             avs_address = 8'h00;
    logic                   avs_read = 1'b0;
    logic                   avs_write = 1'b0;
    logic [31:0]            avs_writedata = 32'h0;
    logic [3:0]             avs_byteenable = 4'h0;
    logic [31:0]            avs_readdata;
    logic                   avs_waitrequest;
    pdc_pkg::pdc_dev_ctrl_s dev_ctrl;
    logic                   hot_plug_en;
    logic [31:0]            rd;
    int                     mismatches = 0;
    int                     samples_checked = 0;

    pdc_regs u_pdc_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hot_plug_strap_i(hp_strap),
        .forward_bridge_strap_i(fwd_strap), .ssp_msg_i(ssp_msg), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .dev_ctrl_o(dev_ctrl), .hot_plug_en_o(hot_plug_en));
    pdc_link_partner u_pdc_link_partner (.clk_i(clk_i), .msg_o(ssp_msg));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_i);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'h0, q);
        samples_checked++;
        if (q !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, q);
        end
    endtask : rd_chk

    task automatic val_chk(input logic [31:0] exp, input logic [31:0] seen, input string what);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : val_chk

    task automatic reset_dut(input logic hp, input logic fwd);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        hp_strap <= hp;
        fwd_strap <= fwd;
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Straps are caught a few edges after release
        repeat (6) @(posedge clk_i);
    endtask : reset_dut

    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        reset_dut(1'b1, 1'b1);
        rd_chk(8'hB4, 32'h00007021, "cap reset");
        val_chk(32'h00000001, {31'h0, hot_plug_en}, "hot plug on");
        rd_chk(8'hB8, 32'h00002000, "ctl reset");
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 8'hB8, ROWS[i].data, ROWS[i].be, rd);
            rd_chk(8'hB8, ROWS[i].exp, "ctl row");
            val_chk({18'h0, ROWS[i].exp[3:0], ROWS[i].exp[7:5], ROWS[i].exp[8],
                     ROWS[i].exp[14:12], ROWS[i].exp[15], 2'b00}, {18'h0, dev_ctrl}, "ctl out");
        end
        bus(1'b1, 8'hB4, 32'hFFFFFFFF, 4'hF, rd);
        bus(1'b1, 8'hC4, 32'hFFFFFFFF, 4'hF, rd);
        rd_chk(8'hC4, 32'h00000000, "unmapped");
        u_pdc_link_partner.send(8'hA5, 2'h2);
        rd_chk(8'hB4, 32'h0A947021, "power a");
        u_pdc_link_partner.send(8'hFF, 2'h3);
        u_pdc_link_partner.send(8'h01, 2'h1);
        rd_chk(8'hB4, 32'h04047021, "power b");
        reset_dut(1'b1, 1'b0);
        rd_chk(8'hB4, 32'h00006021, "cap reverse");
        rd_chk(8'hB8, 32'h00002000, "ctl rereset");
        reset_dut(1'b0, 1'b1);
        rd_chk(8'hB4, 32'h00000021, "cap no hot plug");
        val_chk(32'h00000000, {31'h0, hot_plug_en}, "hot plug off");
        report_and_stop();
    end
endmodule : testbench
